// ===== rtl/periodic_timebase_tick.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module periodic_timebase_tick (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Crystal clock from the clock generator, sampled as a pin
    input wire logic crystal_clock,
    // Low-power state of the processor
    input wire logic wait_mode,
    input wire logic stop_mode,
    // Requests to the processor
    output logic irq,
    output logic wakeup
);

    tick_if tl ();

    logic xtal_s1;
    logic xtal_s2;
    logic xtal_s3;
    logic xtal_level;
    logic run_enable;
    logic tick_irq_enable;
    logic tick_flag;
    logic [2:0] tap_select;
    logic extra_prescale_select;
    logic osc_kept_in_stop_option;
    logic granted;
    logic write_fire;
    logic hit_control;
    logic hit_config;
    logic ack_write;
    logic [31:0] next_rdata;

    // ****************************************************
    // Crystal clock sampling
    // ****************************************************
    // Three stages; the first only feeds the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_s1 <= 1'h0;
            xtal_s2 <= 1'h0;
            xtal_s3 <= 1'h0;
        end else if (ce) begin
            xtal_s1 <= crystal_clock;
            xtal_s2 <= xtal_s1;
            xtal_s3 <= xtal_s2;
        end
    end

    // Accepted level moves only when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_level <= 1'h0;
        end else if (ce && (xtal_s2 == xtal_s3)) begin
            xtal_level <= xtal_s3;
        end
    end

    // ****************************************************
    // Divider hookup
    // ****************************************************
    // Crystal edge is the only thing that advances the chain;
    // in stop without the oscillator option the chain just idles
    assign tl.advance = xtal_s2 && xtal_s3 && !xtal_level;
    assign tl.run = run_enable;
    assign tl.active = !stop_mode || osc_kept_in_stop_option;
    assign tl.prescale = extra_prescale_select;
    assign tl.tap = tap_select;

    tick_divider i_tick_divider (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tl(tl)
    );

    // ****************************************************
    // APB decode
    // ****************************************************
    // Write lands at the access edge, which is the one with pready
    assign write_fire = psel && penable && pready && pwrite;
    assign hit_control = paddr == timebase_pkg::CONTROL_OFFSET;
    assign hit_config = paddr == timebase_pkg::CONFIG_OFFSET;
    assign ack_write = write_fire && granted && hit_control &&
        pwdata[timebase_pkg::ACK_BIT];

    // Read value; acknowledge bit has no storage and reads zero
    always_comb begin
        next_rdata = 32'h00000000;
        if (hit_control) begin
            next_rdata[timebase_pkg::FLAG_BIT] = tick_flag;
            next_rdata[timebase_pkg::TAP_LSB +: 3] = tap_select;
            next_rdata[timebase_pkg::ACK_BIT] = 1'h0;
            next_rdata[timebase_pkg::IRQ_EN_BIT] = tick_irq_enable;
            next_rdata[timebase_pkg::RUN_BIT] = run_enable;
        end else if (hit_config) begin
            next_rdata[timebase_pkg::PRESCALE_BIT] = extra_prescale_select;
            next_rdata[timebase_pkg::OSC_STOP_BIT] = osc_kept_in_stop_option;
        end
    end

    // Answer one cycle after setup, every time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'h0;
        end else if (ce) begin
            pready <= psel && !penable;
        end
    end

    // Access rights are judged at setup; wait and stop lock the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            granted <= 1'h0;
        end else if (ce && psel && !penable) begin
            granted <= !wait_mode && !stop_mode;
        end
    end

    // Read data captured at setup; blocked reads see zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable) begin
            if (!pwrite && !wait_mode && !stop_mode) begin
                prdata <= next_rdata;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Unmapped addresses answer with an error, nothing else
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'h0;
        end else if (ce) begin
            pslverr <= psel && !penable && !(hit_control || hit_config);
        end
    end

    // ****************************************************
    // Control register
    // ****************************************************
    // Run, enable and tap; tap changes while running are not
    // guarded here, so a careless change may skip one tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_enable <= timebase_pkg::RUN_RESET;
            tick_irq_enable <= timebase_pkg::IRQ_EN_RESET;
            tap_select <= timebase_pkg::TAP_RESET;
        end else if (ce && write_fire && granted && hit_control) begin
            run_enable <= pwdata[timebase_pkg::RUN_BIT];
            tick_irq_enable <= pwdata[timebase_pkg::IRQ_EN_BIT];
            tap_select <= pwdata[timebase_pkg::TAP_LSB +: 3];
        end
    end

    // Configuration options
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extra_prescale_select <= timebase_pkg::PRESCALE_RESET;
            osc_kept_in_stop_option <= timebase_pkg::OSC_STOP_RESET;
        end else if (ce && write_fire && granted && hit_config) begin
            extra_prescale_select <= pwdata[timebase_pkg::PRESCALE_BIT];
            osc_kept_in_stop_option <= pwdata[timebase_pkg::OSC_STOP_BIT];
        end
    end

    // Tick flag; a tick in the acknowledge cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_flag <= timebase_pkg::FLAG_RESET;
        end else if (ce) begin
            if (tl.tick) begin
                tick_flag <= 1'h1;
            end else if (ack_write) begin
                tick_flag <= 1'h0;
            end
        end
    end

    // ****************************************************
    // Requests
    // ****************************************************
    // Interrupt and stop wakeup, both registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'h0;
            wakeup <= 1'h0;
        end else if (ce) begin
            irq <= tick_flag && tick_irq_enable;
            wakeup <= tick_flag && tick_irq_enable && stop_mode;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    flag_set_a: assert property (ce && tl.tick |=> tick_flag)
        else $error("tick did not set flag");

    ack_clear_a: assert property (ce && ack_write && !tl.tick
        |=> !tick_flag)
        else $error("acknowledge did not clear flag");

    ack_zero_a: assert property (ce && write_fire && granted &&
        hit_control && !pwdata[timebase_pkg::ACK_BIT] && !tl.tick
        |=> tick_flag == $past(tick_flag))
        else $error("zero acknowledge changed flag");

    ack_read_a: assert property (pready && !pwrite
        |-> !prdata[timebase_pkg::ACK_BIT])
        else $error("acknowledge bit read as one");

    // Checked one edge on, so an acknowledge in between cannot trip it
    irq_follow_a: assert property (ce && tick_flag && tick_irq_enable
        |=> irq)
        else $error("interrupt not raised");

    blocked_a: assert property (ce && write_fire && !granted
        |=> $stable(run_enable) && $stable(tick_irq_enable) &&
        $stable(tap_select))
        else $error("blocked write changed register");

    flag_cause_a: assert property ($rose(tick_flag) |-> $past(tl.tick))
        else $error("flag set without tick");

    wake_a: assert property (ce && irq && stop_mode && tick_flag &&
        tick_irq_enable |=> wakeup)
        else $error("no wakeup in stop");

    answer_a: assert property (ce && psel && !penable |=> pready)
        else $error("no answer after setup");

    tick_seen_c: cover property (ce && tl.tick);
    ack_seen_c: cover property (ack_write && tick_flag);
    wake_seen_c: cover property (wakeup);
    blocked_c: cover property (write_fire && !granted);

`default_nettype wire
endmodule

// ===== rtl/tick_divider.sv
`timescale 1ns/100ps
`default_nettype none

module tick_divider (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Control link
    tick_if.divider tl
);

    logic [timebase_pkg::COUNT_WIDTH-1:0] next_count;
    logic [4:0] tap_bit;

    // ****************************************************
    // Tap decode
    // ****************************************************
    // Prescale only moves the tap up the same chain
    always_comb begin
        next_count = tl.count + 22'h000001;
        tap_bit = timebase_pkg::TAP_BIT[tl.tap];
        if (tl.prescale) begin
            tap_bit = tap_bit + timebase_pkg::PRESCALE_SHIFT;
        end
    end

    // ****************************************************
    // Divider counter
    // ****************************************************
    // One chain of 15 stages plus 7 prescale stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tl.count <= '0;
        end else if (ce) begin
            if (!tl.run) begin
                tl.count <= '0;
            end else if (tl.active && tl.advance) begin
                tl.count <= next_count;
            end
        end
    end

    // Rising edge of the tap bit: first after half, then each period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tl.tick <= 1'h0;
        end else if (ce) begin
            tl.tick <= tl.run && tl.active && tl.advance &&
                next_count[tap_bit] && !tl.count[tap_bit];
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    clear_hold_a: assert property (ce && !tl.run |=> tl.count == '0)
        else $error("divider not held at zero while stopped");

    count_step_a: assert property (ce && tl.run && tl.active && tl.advance
        |=> tl.count == 22'($past(tl.count) + 22'h000001))
        else $error("divider did not step on crystal edge");

    stop_idle_a: assert property (ce && tl.run && !tl.active
        |=> $stable(tl.count))
        else $error("divider moved while idle in stop");

    tick_phase_a: assert property (tl.tick |->
        tl.count[tap_bit] && ((tl.count &
        ((22'h000001 << tap_bit) - 22'h000001)) == '0))
        else $error("tick not at tap bit rising edge");

    first_tick_c: cover property (ce && tl.tick && tl.count[21]);

`default_nettype wire
endmodule

// ===== rtl/tick_if.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// Control side to divider side
// ****************************************************
interface tick_if;
    logic run;
    logic active;
    logic advance;
    logic prescale;
    logic [2:0] tap;
    logic tick;
    logic [timebase_pkg::COUNT_WIDTH-1:0] count;

    modport control (
        output run,
        output active,
        output advance,
        output prescale,
        output tap,
        input tick,
        input count
    );

    modport divider (
        input run,
        input active,
        input advance,
        input prescale,
        input tap,
        output tick,
        output count
    );
endinterface

`default_nettype wire

// ===== rtl/timebase_pkg.sv
package timebase_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [11:0] CONTROL_OFFSET = 12'h000;
    localparam logic [11:0] CONFIG_OFFSET = 12'h004;

    // Control register fields
    localparam int FLAG_BIT = 7;
    localparam int TAP_LSB = 4;
    localparam int ACK_BIT = 3;
    localparam int IRQ_EN_BIT = 2;
    localparam int RUN_BIT = 1;

    // Configuration register fields
    localparam int PRESCALE_BIT = 0;
    localparam int OSC_STOP_BIT = 1;

    // Reset values
    localparam logic [2:0] TAP_RESET = 3'h0;
    localparam logic RUN_RESET = 1'h0;
    localparam logic IRQ_EN_RESET = 1'h0;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic PRESCALE_RESET = 1'h0;
    localparam logic OSC_STOP_RESET = 1'h0;

    // ****************************************************
    // Divider chain
    // ****************************************************
    localparam int STAGE_COUNT = 15;
    localparam int PRESCALE_STAGES = 7;
    localparam int COUNT_WIDTH = STAGE_COUNT + PRESCALE_STAGES;
    localparam logic [4:0] PRESCALE_SHIFT = 5'h7;

    // Counter bit whose rising edge marks a tick, per tap code
    // Codes 0..7: periods 32768, 8192, 2048, 128, 64, 32, 16, 8
    localparam logic [7:0][4:0] TAP_BIT =
        {5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'hA, 5'hC, 5'hE};

endpackage

// ===== tb/periodic_timebase_tick_bench.sv
`timescale 1ns/100ps
`default_nettype none

module periodic_timebase_tick_bench;
    // ****************************************************
    // Signals
    // ****************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic crystal_clock, wait_mode, stop_mode, irq, wakeup, err, crystal_on;
    logic [3:0] phase;
    int edges, base, mismatches, comparisons, cycles;

    periodic_timebase_tick i_periodic_timebase_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ce(1'h1),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .crystal_clock(crystal_clock),
        .wait_mode(wait_mode),
        .stop_mode(stop_mode),
        .irq(irq),
        .wakeup(wakeup)
    );

    // Clock and cycle ceiling
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            results();
        end
    end

    // Crystal: 16 pclk period, well clear of the sync latency; low when off
    always @(posedge pclk) begin
        phase <= crystal_on ? phase + 4'h1 : 4'h0;
        crystal_clock <= crystal_on & phase[3];
        if (crystal_on && phase == 4'h8) begin
            edges <= edges + 1;
        end
    end

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] ctl(input logic f, input logic [2:0] t,
            input logic ie, input logic run, input logic ack);
        ctl = 32'h0;
        ctl[timebase_pkg::FLAG_BIT] = f;
        ctl[timebase_pkg::TAP_LSB +: 3] = t;
        ctl[timebase_pkg::IRQ_EN_BIT] = ie;
        ctl[timebase_pkg::RUN_BIT] = run;
        ctl[timebase_pkg::ACK_BIT] = ack;
    endfunction

    // Setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wctl(input logic [31:0] d);
        apb(1'h1, timebase_pkg::CONTROL_OFFSET, d);
    endtask

    task automatic rctl(input logic [31:0] exp);
        apb(1'h0, timebase_pkg::CONTROL_OFFSET, 32'h0);
        check(rd, exp);
    endtask

    task automatic wait_irq(input int limit);
        int n;
        n = 0;
        while (irq !== 1'h1 && n < limit) begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, irq}, 32'h1);
    endtask

    // Tap is changed only with the run bit clear, then run is set
    task automatic start(input logic [2:0] t, input logic [31:0] cfg);
        wctl(ctl(0, t, 0, 0, 1));
        crystal_on <= 1'h0;
        apb(1'h1, timebase_pkg::CONFIG_OFFSET, cfg);
        wctl(ctl(0, t, 1, 1, 0));
        base = edges;
        crystal_on <= 1'h1;
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic reset_values();
        rctl(32'h0);
        apb(1'h0, timebase_pkg::CONFIG_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask

    task automatic tick_rate(input logic [2:0] t, input logic ps, input int p);
        int e1;
        start(t, {31'h0, ps});
        wait_irq(p * 8 + 64);
        e1 = edges;
        check(32'(e1 - base), 32'(p / 2));
        rctl(ctl(1, t, 1, 1, 0));
        wctl(ctl(0, t, 1, 1, 1));
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        wait_irq(p * 16 + 64);
        check(32'(edges - e1), 32'(p));
    endtask

    task automatic mask_and_ack();
        start(3'h7, 32'h0);
        wait_irq(200);
        wctl(ctl(0, 7, 1, 1, 0));
        rctl(ctl(1, 7, 1, 1, 0));
        wctl(ctl(0, 7, 0, 1, 0));
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rctl(ctl(1, 7, 0, 1, 0));
        wctl(ctl(1, 7, 0, 0, 1));
        rctl(ctl(0, 7, 0, 0, 0));
        repeat (400) @(posedge pclk);
        rctl(ctl(0, 7, 0, 0, 0));
    endtask

    task automatic wait_access();
        start(3'h7, 32'h0);
        wait_mode <= 1'h1;
        wctl(32'h0);
        rctl(32'h0);
        wait_irq(200);
        wait_mode <= 1'h0;
        rctl(ctl(1, 7, 1, 1, 0));
    endtask

    task automatic stop_behaviour();
        start(3'h7, 32'h0);
        stop_mode <= 1'h1;
        repeat (400) @(posedge pclk);
        check({30'h0, irq, wakeup}, 32'h0);
        wctl(32'h0);
        rctl(32'h0);
        stop_mode <= 1'h0;
        rctl(ctl(0, 7, 1, 1, 0));
        start(3'h7, 32'h2);
        stop_mode <= 1'h1;
        wait_irq(200);
        check(32'(edges - base), 32'h4);
        @(posedge pclk);
        check({31'h0, wakeup}, 32'h1);
        stop_mode <= 1'h0;
        repeat (2) @(posedge pclk);
        check({31'h0, wakeup}, 32'h0);
    endtask

    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, wait_mode, stop_mode, crystal_on} = 6'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        crystal_clock = 1'h0;
        phase = 4'h0;
        edges = 0;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        reset_values();
        for (int t = 7; t >= 3; t--) begin
            tick_rate(3'(t), 1'h0, 8 << (7 - t));
        end
        tick_rate(3'h7, 1'h1, 1024);
        mask_and_ack();
        wait_access();
        stop_behaviour();
        results();
    end
endmodule

`default_nettype wire
